/* File: rtl/siu_device.sv */
// Interrupt unit: pending flags, global enable and the interrupt machine cycle
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/10ps

// Function
// - One shared vector at lowest ROM bytes
// - Mode register bit 3 is global enable
// - Enable/disable instructions set and clear enable
// - Software enables interrupts after every reset
// - Source sets pending flag until cleared
// - Handler clears its flag before return
// - Acknowledge needs global and source enable
// - Acknowledge only at instruction boundary
// - Machine cycle first clears global enable
// - Push PC low, PC high, flags
// - Fetch vector high then low, branch
// - Return pops state and re-enables
// - Software polling decides service order
// - Acknowledge pulse before service routine
// - Fourteen request inputs combined
// - Load with zero clears that flag
module siu_device (
	input wire logic clk,
	input wire logic reset,
	siu_link_if.dev lk,
	input wire logic [siu_pkg::SIU_NUM_SRC-1:0] src_set,
	input wire logic [siu_pkg::SIU_NUM_SRC-1:0] src_en,
	output logic global_int_enable,
	output logic [siu_pkg::SIU_NUM_SRC-1:0] pending
);
	typedef struct packed {
		siu_pkg::siu_state_t state;
		logic [7:0] mode;
		logic [siu_pkg::SIU_NUM_SRC-1:0] pend;
		logic [15:0] pc;
		logic [7:0] flags;
		logic [7:0] vec_hi;
		logic [7:0] reg_rdata;
		logic int_ack;
		logic busy;
		logic mem_req;
		siu_pkg::siu_op_t mem_op;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
		logic branch_valid;
		logic restore_valid;
	} siu_dev_t;

	siu_dev_t s_ff;
	siu_dev_t nxt_s;

	localparam siu_dev_t SIU_DEV_RESET = '{
		state: siu_pkg::SIU_ST_IDLE,
		mode: siu_pkg::SIU_MODE_RESET,
		pend: '0,
		pc: '0,
		flags: '0,
		vec_hi: '0,
		reg_rdata: '0,
		int_ack: 1'b0,
		busy: 1'b0,
		mem_req: 1'b0,
		mem_op: siu_pkg::SIU_OP_PUSH,
		mem_addr: '0,
		mem_wdata: '0,
		branch_valid: 1'b0,
		restore_valid: 1'b0
	};

	logic take_irq;

	// Any source with its own enable set, gated globally
	assign take_irq = s_ff.mode[siu_pkg::SIU_GIE_BIT] && (|(s_ff.pend & src_en));

	always_comb begin
		nxt_s = s_ff;
		nxt_s.int_ack = 1'b0;
		nxt_s.branch_valid = 1'b0;
		nxt_s.restore_valid = 1'b0;

		// Software clears flags written as zero only
		if (lk.reg_wr && lk.reg_addr == siu_pkg::SIU_PEND1_ADDR) begin
			nxt_s.pend[siu_pkg::SIU_PEND1_W-1:0] = s_ff.pend[siu_pkg::SIU_PEND1_W-1:0]
				& lk.reg_wdata;
		end else if (lk.reg_wr && lk.reg_addr == siu_pkg::SIU_PEND2_ADDR) begin
			nxt_s.pend[siu_pkg::SIU_NUM_SRC-1:siu_pkg::SIU_PEND1_W] =
				s_ff.pend[siu_pkg::SIU_NUM_SRC-1:siu_pkg::SIU_PEND1_W]
				& lk.reg_wdata[siu_pkg::SIU_PEND2_W-1:0];
		end
		// New request wins over a clear in the same cycle
		nxt_s.pend = nxt_s.pend | src_set;

		if (lk.reg_wr && lk.reg_addr == siu_pkg::SIU_MODE_ADDR) begin
			nxt_s.mode = lk.reg_wdata;
		end
		if (lk.int_on_exec) begin
			nxt_s.mode[siu_pkg::SIU_GIE_BIT] = 1'b1;
		end
		if (lk.int_off_exec) begin
			nxt_s.mode[siu_pkg::SIU_GIE_BIT] = 1'b0;
		end

		if (lk.reg_rd) begin
			if (lk.reg_addr == siu_pkg::SIU_MODE_ADDR) begin
				nxt_s.reg_rdata = s_ff.mode;
			end else if (lk.reg_addr == siu_pkg::SIU_PEND1_ADDR) begin
				nxt_s.reg_rdata = s_ff.pend[siu_pkg::SIU_PEND1_W-1:0];
			end else if (lk.reg_addr == siu_pkg::SIU_PEND2_ADDR) begin
				nxt_s.reg_rdata = {2'h0, s_ff.pend[siu_pkg::SIU_NUM_SRC-1:siu_pkg::SIU_PEND1_W]};
			end else begin
				nxt_s.reg_rdata = 8'h00;
			end
		end

		case (s_ff.state)
			siu_pkg::SIU_ST_IDLE: begin
				if (lk.int_ret_exec) begin
					nxt_s.state = siu_pkg::SIU_ST_POP_FLG;
					nxt_s.busy = 1'b1;
				end else if (lk.instr_end && take_irq) begin
					nxt_s.int_ack = 1'b1;
					nxt_s.mode[siu_pkg::SIU_GIE_BIT] = 1'b0;
					nxt_s.pc = lk.cur_pc;
					nxt_s.flags = lk.cur_flags;
					nxt_s.busy = 1'b1;
					nxt_s.state = siu_pkg::SIU_ST_PUSH_PCL;
				end
			end
			default: begin
				if (!s_ff.mem_req) begin
					// Issue the memory step of the current state
					nxt_s.mem_req = 1'b1;
					case (s_ff.state)
						siu_pkg::SIU_ST_PUSH_PCL: begin
							nxt_s.mem_op = siu_pkg::SIU_OP_PUSH;
							nxt_s.mem_wdata = s_ff.pc[7:0];
						end
						siu_pkg::SIU_ST_PUSH_PCH: begin
							nxt_s.mem_op = siu_pkg::SIU_OP_PUSH;
							nxt_s.mem_wdata = s_ff.pc[15:8];
						end
						siu_pkg::SIU_ST_PUSH_FLG: begin
							nxt_s.mem_op = siu_pkg::SIU_OP_PUSH;
							nxt_s.mem_wdata = s_ff.flags;
						end
						siu_pkg::SIU_ST_FETCH_HI: begin
							nxt_s.mem_op = siu_pkg::SIU_OP_ROM;
							nxt_s.mem_addr = siu_pkg::SIU_VEC_HI_ADDR;
						end
						siu_pkg::SIU_ST_FETCH_LO: begin
							nxt_s.mem_op = siu_pkg::SIU_OP_ROM;
							nxt_s.mem_addr = siu_pkg::SIU_VEC_LO_ADDR;
						end
						default: begin
							nxt_s.mem_op = siu_pkg::SIU_OP_POP;
						end
					endcase
				end else if (lk.mem_done) begin
					nxt_s.mem_req = 1'b0;
					case (s_ff.state)
						siu_pkg::SIU_ST_PUSH_PCL: begin
							nxt_s.state = siu_pkg::SIU_ST_PUSH_PCH;
						end
						siu_pkg::SIU_ST_PUSH_PCH: begin
							nxt_s.state = siu_pkg::SIU_ST_PUSH_FLG;
						end
						siu_pkg::SIU_ST_PUSH_FLG: begin
							nxt_s.state = siu_pkg::SIU_ST_FETCH_HI;
						end
						siu_pkg::SIU_ST_FETCH_HI: begin
							nxt_s.vec_hi = lk.mem_rdata;
							nxt_s.state = siu_pkg::SIU_ST_FETCH_LO;
						end
						siu_pkg::SIU_ST_FETCH_LO: begin
							nxt_s.pc = {s_ff.vec_hi, lk.mem_rdata};
							nxt_s.branch_valid = 1'b1;
							nxt_s.busy = 1'b0;
							nxt_s.state = siu_pkg::SIU_ST_IDLE;
						end
						siu_pkg::SIU_ST_POP_FLG: begin
							nxt_s.flags = lk.mem_rdata;
							nxt_s.state = siu_pkg::SIU_ST_POP_PCH;
						end
						siu_pkg::SIU_ST_POP_PCH: begin
							nxt_s.pc[15:8] = lk.mem_rdata;
							nxt_s.state = siu_pkg::SIU_ST_POP_PCL;
						end
						default: begin
							nxt_s.pc[7:0] = lk.mem_rdata;
							nxt_s.restore_valid = 1'b1;
							nxt_s.mode[siu_pkg::SIU_GIE_BIT] = 1'b1;
							nxt_s.busy = 1'b0;
							nxt_s.state = siu_pkg::SIU_ST_IDLE;
						end
					endcase
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_ff <= SIU_DEV_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lk.reg_rdata = s_ff.reg_rdata;
	assign lk.int_ack = s_ff.int_ack;
	assign lk.busy = s_ff.busy;
	assign lk.mem_req = s_ff.mem_req;
	assign lk.mem_op = s_ff.mem_op;
	assign lk.mem_addr = s_ff.mem_addr;
	assign lk.mem_wdata = s_ff.mem_wdata;
	assign lk.branch_valid = s_ff.branch_valid;
	assign lk.restore_valid = s_ff.restore_valid;
	assign lk.load_pc = s_ff.pc;
	assign lk.load_flags = s_ff.flags;
	assign global_int_enable = s_ff.mode[siu_pkg::SIU_GIE_BIT];
	assign pending = s_ff.pend;
endmodule : siu_device

/* File: rtl/siu_link_if.sv */
// Link between the interrupt unit and the CPU sequencer
`timescale 1ns/10ps
interface siu_link_if;
	logic instr_end;
	logic int_on_exec;
	logic int_off_exec;
	logic int_ret_exec;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic [15:0] cur_pc;
	logic [7:0] cur_flags;
	logic int_ack;
	logic busy;
	logic mem_req;
	siu_pkg::siu_op_t mem_op;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata;
	logic mem_done;
	logic [7:0] mem_rdata;
	logic branch_valid;
	logic restore_valid;
	logic [15:0] load_pc;
	logic [7:0] load_flags;

	modport dev (
		input instr_end, int_on_exec, int_off_exec, int_ret_exec, reg_wr, reg_rd, reg_addr, reg_wdata,
		input cur_pc, cur_flags, mem_done, mem_rdata,
		output reg_rdata, int_ack, busy, mem_req, mem_op, mem_addr, mem_wdata,
		output branch_valid, restore_valid, load_pc, load_flags
	);
	modport seq (
		output instr_end, int_on_exec, int_off_exec, int_ret_exec, reg_wr, reg_rd, reg_addr, reg_wdata,
		output cur_pc, cur_flags, mem_done, mem_rdata,
		input reg_rdata, int_ack, busy, mem_req, mem_op, mem_addr, mem_wdata,
		input branch_valid, restore_valid, load_pc, load_flags
	);
endinterface : siu_link_if

/* File: rtl/siu_pkg.sv */
// Shared constants, register map and types of the single-vector interrupt unit
package siu_pkg;
	localparam int SIU_NUM_SRC = 14;
	localparam int SIU_PEND1_W = 8;
	localparam int SIU_PEND2_W = 6;

	// Device register file addresses
	localparam logic [7:0] SIU_MODE_ADDR = 8'hDF;
	localparam logic [7:0] SIU_PEND1_ADDR = 8'hD0;
	localparam logic [7:0] SIU_PEND2_ADDR = 8'hD1;
	localparam logic [7:0] SIU_MODE_RESET = 8'h00;
	localparam int SIU_GIE_BIT = 3;

	// Source positions in the flat pending vector
	localparam int SIU_SRC_P0_0 = 0;
	localparam int SIU_SRC_P1_0 = 4;
	localparam int SIU_SRC_T1A = 8;
	localparam int SIU_SRC_TB = 9;
	localparam int SIU_SRC_SER = 10;
	localparam int SIU_SRC_WT = 11;
	localparam int SIU_SRC_P3_0 = 12;

	// Vector bytes in program memory
	localparam logic [15:0] SIU_VEC_HI_ADDR = 16'h0000;
	localparam logic [15:0] SIU_VEC_LO_ADDR = 16'h0001;

	// Memory operation codes on the link
	typedef enum logic [1:0] {
		SIU_OP_PUSH,
		SIU_OP_POP,
		SIU_OP_ROM
	} siu_op_t;

	typedef enum logic [3:0] {
		SIU_ST_IDLE,
		SIU_ST_PUSH_PCL,
		SIU_ST_PUSH_PCH,
		SIU_ST_PUSH_FLG,
		SIU_ST_FETCH_HI,
		SIU_ST_FETCH_LO,
		SIU_ST_POP_FLG,
		SIU_ST_POP_PCH,
		SIU_ST_POP_PCL
	} siu_state_t;

	// Sequencer registers on AHB-Lite, byte addresses
	localparam logic [7:0] SIU_CTRL_OFS = 8'h00;
	localparam logic [7:0] SIU_REGACC_OFS = 8'h04;
	localparam logic [7:0] SIU_REGRD_OFS = 8'h08;
	localparam logic [7:0] SIU_PC_OFS = 8'h0C;
	localparam logic [7:0] SIU_FLAGS_OFS = 8'h10;
	localparam logic [7:0] SIU_VECTOR_OFS = 8'h14;
	localparam logic [7:0] SIU_STATUS_OFS = 8'h18;
	localparam logic [7:0] SIU_IRQ_STAT_OFS = 8'h1C;
	localparam logic [7:0] SIU_IRQ_MASK_OFS = 8'h20;

	// Command bits of the control register
	localparam int SIU_CMD_BOUNDARY = 0;
	localparam int SIU_CMD_INT_ON = 1;
	localparam int SIU_CMD_INT_OFF = 2;
	localparam int SIU_CMD_INT_RET = 3;
	localparam int SIU_CMD_REG_WR = 4;
	localparam int SIU_CMD_REG_RD = 5;

	// Event bits of the sequencer interrupt status
	localparam int SIU_EV_ACK = 0;
	localparam int SIU_EV_BRANCH = 1;
	localparam int SIU_EV_RESTORE = 2;
	localparam int SIU_EV_W = 3;

	localparam int SIU_STACK_DEPTH = 16;
	localparam int SIU_SP_W = 4;
	localparam logic [1:0] SIU_HTRANS_NONSEQ = 2'h2;
endpackage : siu_pkg

/* File: rtl/siu_sequencer.sv */
// CPU sequencer end: AHB-Lite registers, stack and vector memory
`timescale 1ns/10ps
module siu_sequencer (
	input wire logic clk,
	input wire logic reset,
	siu_link_if.seq lk,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic irq
);
	typedef struct packed {
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic [5:0] cmd;
		logic [7:0] reg_addr;
		logic [7:0] reg_wdata;
		logic [15:0] pc;
		logic [7:0] flags;
		logic [15:0] vector;
		logic [siu_pkg::SIU_SP_W-1:0] sp;
		logic [siu_pkg::SIU_STACK_DEPTH-1:0][7:0] stack;
		logic mem_done;
		logic [7:0] mem_rdata;
		logic [siu_pkg::SIU_EV_W-1:0] irq_stat;
		logic [siu_pkg::SIU_EV_W-1:0] irq_mask;
		logic irq;
	} siu_seq_t;

	siu_seq_t s_ff;
	siu_seq_t nxt_s;
	logic [siu_pkg::SIU_EV_W-1:0] events;
	logic [siu_pkg::SIU_SP_W-1:0] sp_dec;

	assign events = {lk.restore_valid, lk.branch_valid, lk.int_ack};
	assign sp_dec = s_ff.sp - 1'b1;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.cmd = '0;
		nxt_s.mem_done = 1'b0;

		// Register write in the data phase
		if (s_ff.ap_valid && s_ff.ap_write) begin
			nxt_s.ap_valid = 1'b0;
			if (s_ff.ap_addr == siu_pkg::SIU_CTRL_OFS) begin
				nxt_s.cmd = hwdata[5:0];
			end else if (s_ff.ap_addr == siu_pkg::SIU_REGACC_OFS) begin
				nxt_s.reg_addr = hwdata[7:0];
				nxt_s.reg_wdata = hwdata[15:8];
			end else if (s_ff.ap_addr == siu_pkg::SIU_PC_OFS) begin
				nxt_s.pc = hwdata[15:0];
			end else if (s_ff.ap_addr == siu_pkg::SIU_FLAGS_OFS) begin
				nxt_s.flags = hwdata[7:0];
			end else if (s_ff.ap_addr == siu_pkg::SIU_VECTOR_OFS) begin
				nxt_s.vector = hwdata[15:0];
			end else if (s_ff.ap_addr == siu_pkg::SIU_IRQ_STAT_OFS) begin
				nxt_s.irq_stat = s_ff.irq_stat & ~hwdata[siu_pkg::SIU_EV_W-1:0];
			end else if (s_ff.ap_addr == siu_pkg::SIU_IRQ_MASK_OFS) begin
				nxt_s.irq_mask = hwdata[siu_pkg::SIU_EV_W-1:0];
			end
		end
		// Read wait state: load data, then release hready
		if (s_ff.ap_valid && !s_ff.ap_write) begin
			nxt_s.ap_valid = 1'b0;
			nxt_s.hreadyout = 1'b1;
			if (s_ff.ap_addr == siu_pkg::SIU_REGACC_OFS) begin
				nxt_s.hrdata = {16'h0000, s_ff.reg_wdata, s_ff.reg_addr};
			end else if (s_ff.ap_addr == siu_pkg::SIU_REGRD_OFS) begin
				nxt_s.hrdata = {24'h000000, lk.reg_rdata};
			end else if (s_ff.ap_addr == siu_pkg::SIU_PC_OFS) begin
				nxt_s.hrdata = {16'h0000, s_ff.pc};
			end else if (s_ff.ap_addr == siu_pkg::SIU_FLAGS_OFS) begin
				nxt_s.hrdata = {24'h000000, s_ff.flags};
			end else if (s_ff.ap_addr == siu_pkg::SIU_VECTOR_OFS) begin
				nxt_s.hrdata = {16'h0000, s_ff.vector};
			end else if (s_ff.ap_addr == siu_pkg::SIU_STATUS_OFS) begin
				nxt_s.hrdata = {24'h000000, 3'h0, s_ff.sp, lk.busy};
			end else if (s_ff.ap_addr == siu_pkg::SIU_IRQ_STAT_OFS) begin
				nxt_s.hrdata = {29'h00000000, s_ff.irq_stat};
			end else if (s_ff.ap_addr == siu_pkg::SIU_IRQ_MASK_OFS) begin
				nxt_s.hrdata = {29'h00000000, s_ff.irq_mask};
			end else begin
				nxt_s.hrdata = 32'h00000000;
			end
		end
		// Address phase
		if (hsel && hready && htrans == siu_pkg::SIU_HTRANS_NONSEQ) begin
			nxt_s.ap_valid = 1'b1;
			nxt_s.ap_write = hwrite;
			nxt_s.ap_addr = {haddr[7:2], 2'h0};
			if (!hwrite) begin
				nxt_s.hreadyout = 1'b0;
			end
		end

		// Stack and vector memory, one answer per request
		if (lk.mem_req && !s_ff.mem_done) begin
			nxt_s.mem_done = 1'b1;
			case (lk.mem_op)
				siu_pkg::SIU_OP_PUSH: begin
					nxt_s.stack[s_ff.sp] = lk.mem_wdata;
					nxt_s.sp = s_ff.sp + 1'b1;
				end
				siu_pkg::SIU_OP_POP: begin
					nxt_s.mem_rdata = s_ff.stack[sp_dec];
					nxt_s.sp = sp_dec;
				end
				default: begin
					nxt_s.mem_rdata = (lk.mem_addr == siu_pkg::SIU_VEC_HI_ADDR) ? s_ff.vector[15:8]
						: s_ff.vector[7:0];
				end
			endcase
		end

		if (lk.branch_valid) begin
			nxt_s.pc = lk.load_pc;
		end
		if (lk.restore_valid) begin
			nxt_s.pc = lk.load_pc;
			nxt_s.flags = lk.load_flags;
		end

		// Event sets win over software clear
		nxt_s.irq_stat = nxt_s.irq_stat | events;
		nxt_s.irq = |(nxt_s.irq_stat & nxt_s.irq_mask);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_ff <= '0;
			s_ff.hreadyout <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign hrdata = s_ff.hrdata;
	assign hreadyout = s_ff.hreadyout;
	assign hresp = 1'b0;
	assign irq = s_ff.irq;
	assign lk.instr_end = s_ff.cmd[siu_pkg::SIU_CMD_BOUNDARY];
	assign lk.int_on_exec = s_ff.cmd[siu_pkg::SIU_CMD_INT_ON];
	assign lk.int_off_exec = s_ff.cmd[siu_pkg::SIU_CMD_INT_OFF];
	assign lk.int_ret_exec = s_ff.cmd[siu_pkg::SIU_CMD_INT_RET];
	assign lk.reg_wr = s_ff.cmd[siu_pkg::SIU_CMD_REG_WR];
	assign lk.reg_rd = s_ff.cmd[siu_pkg::SIU_CMD_REG_RD];
	assign lk.reg_addr = s_ff.reg_addr;
	assign lk.reg_wdata = s_ff.reg_wdata;
	assign lk.cur_pc = s_ff.pc;
	assign lk.cur_flags = s_ff.flags;
	assign lk.mem_done = s_ff.mem_done;
	assign lk.mem_rdata = s_ff.mem_rdata;
endmodule : siu_sequencer

/* File: verification/siu_assertions.sv */
// Concurrent checks on the link between the interrupt unit and the sequencer
`timescale 1ns/10ps
module siu_assertions (
	input wire logic clk,
	input wire logic reset,
	input wire logic instr_end,
	input wire logic int_ret_exec,
	input wire logic [15:0] cur_pc,
	input wire logic [7:0] cur_flags,
	input wire logic int_ack,
	input wire logic busy,
	input wire logic mem_req,
	input var siu_pkg::siu_op_t mem_op,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_done,
	input wire logic [7:0] mem_rdata,
	input wire logic branch_valid,
	input wire logic restore_valid,
	input wire logic [15:0] load_pc
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_ack_boundary;
		int_ack |-> $past(instr_end) && !$past(busy);
	endproperty
	a_ack_boundary: assert property (p_ack_boundary) else $error("ack without boundary");
	property p_ack_pulse;
		int_ack |=> !int_ack && busy;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");
	property p_busy_no_ack;
		busy && instr_end |=> !int_ack;
	endproperty
	a_busy_no_ack: assert property (p_busy_no_ack) else $error("ack while busy");
	property p_save_order;
		int_ack |=> (mem_req && mem_op == siu_pkg::SIU_OP_PUSH && mem_wdata == cur_pc[7:0])
			##3 (mem_req && mem_op == siu_pkg::SIU_OP_PUSH && mem_wdata == cur_pc[15:8])
			##3 (mem_req && mem_op == siu_pkg::SIU_OP_PUSH && mem_wdata == cur_flags)
			##3 (mem_req && mem_op == siu_pkg::SIU_OP_ROM && mem_addr == 16'h0000)
			##3 (mem_req && mem_op == siu_pkg::SIU_OP_ROM && mem_addr == 16'h0001);
	endproperty
	a_save_order: assert property (p_save_order) else $error("machine cycle order wrong");
	property p_branch_addr;
		mem_req && mem_op == siu_pkg::SIU_OP_ROM && mem_addr == 16'h0001 && mem_done
			|-> ##[1:3] branch_valid && load_pc[7:0] == mem_rdata;
	endproperty
	a_branch_addr: assert property (p_branch_addr) else $error("branch target wrong");
	property p_branch_end;
		branch_valid |=> !busy && !mem_req;
	endproperty
	a_branch_end: assert property (p_branch_end) else $error("busy after branch");
	property p_interrupt_return_instruction_start;
		int_ret_exec && !busy |=> busy ##[0:1] (mem_req && mem_op == siu_pkg::SIU_OP_POP);
	endproperty
	a_interrupt_return_instruction_start: assert property (p_interrupt_return_instruction_start) else $error("return did not pop");
	property p_restore_end;
		restore_valid |=> !busy && !restore_valid;
	endproperty
	a_restore_end: assert property (p_restore_end) else $error("busy after return");
	property p_req_hold;
		mem_req && !mem_done |=> mem_req && $stable(mem_addr) && $stable(mem_op);
	endproperty
	a_req_hold: assert property (p_req_hold) else $error("memory request dropped");
endmodule : siu_assertions

/* File: verification/siu_tb_top.sv */
// Self-checking bench for the single-vector interrupt unit
`timescale 1ns/10ps
module siu_tb_top;
	logic clk;
	logic reset;
	logic [13:0] src_set;
	logic [13:0] src_en;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	logic gen;
	logic [13:0] pending;
	logic [31:0] rd;
	logic [7:0] m;
	int i;
	int error_cnt;
	int tests_run;

	siu_link_if lk ();
	siu_device u_siu_device (.clk(clk), .reset(reset), .lk(lk.dev), .src_set(src_set), .src_en(src_en),
		.global_int_enable(gen), .pending(pending));
	siu_sequencer u_siu_sequencer (.clk(clk), .reset(reset), .lk(lk.seq), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
	siu_assertions u_siu_assertions (.clk(clk), .reset(reset), .instr_end(lk.instr_end),
		.int_ret_exec(lk.int_ret_exec), .cur_pc(lk.cur_pc), .cur_flags(lk.cur_flags), .int_ack(lk.int_ack),
		.busy(lk.busy), .mem_req(lk.mem_req), .mem_op(lk.mem_op), .mem_addr(lk.mem_addr),
		.mem_wdata(lk.mem_wdata), .mem_done(lk.mem_done), .mem_rdata(lk.mem_rdata),
		.branch_valid(lk.branch_valid), .restore_valid(lk.restore_valid), .load_pc(lk.load_pc));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task summarize;
		$display("Checks run %0d, errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	// One AHB-Lite single word transfer, read data left in rd
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= siu_pkg::SIU_HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		if (wr) hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask : ahb

	task rrd(input logic [7:0] a, input logic [31:0] exp, input string name);
		ahb(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask : rrd

	task cmd(input int b);
		ahb(1'b1, siu_pkg::SIU_CTRL_OFS, 32'h1 << b);
		repeat (3) @(posedge clk);
	endtask : cmd

	task dev(input logic [7:0] a, input logic [7:0] d, input int b);
		ahb(1'b1, siu_pkg::SIU_REGACC_OFS, {16'h0, d, a});
		cmd(b);
	endtask : dev

	task wait_idle;
		int n;
		n = 0;
		ahb(1'b0, siu_pkg::SIU_STATUS_OFS, 32'h0);
		while (rd[0] !== 1'b0 && n < 40) begin
			ahb(1'b0, siu_pkg::SIU_STATUS_OFS, 32'h0);
			n++;
		end
		chk("busy", 32'(rd[0]), 32'h0);
	endtask : wait_idle

	task pulse(input logic [13:0] b);
		src_set <= b;
		@(posedge clk);
		src_set <= 14'h0000;
		@(posedge clk);
	endtask : pulse

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end

	initial begin
		reset = 1'b1;
		src_set = 14'h0000;
		src_en = 14'h3FFF;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		error_cnt = 0;
		tests_run = 0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		dev(siu_pkg::SIU_MODE_ADDR, 8'h00, siu_pkg::SIU_CMD_REG_RD);
		rrd(siu_pkg::SIU_REGRD_OFS, 32'h0, "mode_reset");
		chk("gen_reset", 32'(gen), 32'h0);
		pulse(14'h0004);
		chk("pend_set", 32'(pending), 32'h4);
		cmd(siu_pkg::SIU_CMD_BOUNDARY);
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h0, "no_ack_gen_off");
		cmd(siu_pkg::SIU_CMD_INT_ON);
		chk("gen_on", 32'(gen), 32'h1);
		dev(siu_pkg::SIU_MODE_ADDR, 8'h00, siu_pkg::SIU_CMD_REG_RD);
		rrd(siu_pkg::SIU_REGRD_OFS, 32'h8, "mode_bit3");
		cmd(siu_pkg::SIU_CMD_INT_OFF);
		chk("gen_off", 32'(gen), 32'h0);
		dev(siu_pkg::SIU_MODE_ADDR, 8'h08, siu_pkg::SIU_CMD_REG_WR);
		chk("gen_direct", 32'(gen), 32'h1);
		src_en <= 14'h0000;
		cmd(siu_pkg::SIU_CMD_BOUNDARY);
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h0, "no_ack_src_off");
		ahb(1'b1, siu_pkg::SIU_PC_OFS, 32'h1234);
		ahb(1'b1, siu_pkg::SIU_FLAGS_OFS, 32'hA5);
		ahb(1'b1, siu_pkg::SIU_VECTOR_OFS, 32'hBEEF);
		ahb(1'b1, siu_pkg::SIU_IRQ_MASK_OFS, 32'h7);
		src_en <= 14'h3FFF;
		cmd(siu_pkg::SIU_CMD_BOUNDARY);
		// Boundary during the machine cycle must not stack a second entry
		cmd(siu_pkg::SIU_CMD_BOUNDARY);
		wait_idle();
		chk("gen_cleared", 32'(gen), 32'h0);
		rrd(siu_pkg::SIU_PC_OFS, 32'hBEEF, "vector");
		rrd(siu_pkg::SIU_STATUS_OFS, 32'h6, "stack_depth");
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h3, "ack_seen");
		chk("irq_on", 32'(irq), 32'h1);
		chk("hresp", 32'(hresp), 32'h0);
		chk("pend_kept", 32'(pending), 32'h4);
		ahb(1'b1, siu_pkg::SIU_IRQ_MASK_OFS, 32'h0);
		repeat (2) @(posedge clk);
		chk("irq_masked", 32'(irq), 32'h0);
		ahb(1'b1, siu_pkg::SIU_IRQ_STAT_OFS, 32'h3);
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h0, "stat_cleared");
		ahb(1'b1, siu_pkg::SIU_IRQ_MASK_OFS, 32'h7);
		cmd(siu_pkg::SIU_CMD_BOUNDARY);
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h0, "no_ack_in_handler");
		pulse(14'h0809);
		// Handler polls both pending registers to choose its order
		dev(siu_pkg::SIU_PEND1_ADDR, 8'h00, siu_pkg::SIU_CMD_REG_RD);
		rrd(siu_pkg::SIU_REGRD_OFS, 32'hD, "poll_first");
		dev(siu_pkg::SIU_PEND2_ADDR, 8'h00, siu_pkg::SIU_CMD_REG_RD);
		rrd(siu_pkg::SIU_REGRD_OFS, 32'h8, "poll_second");
		dev(8'hD0, 8'hFB, siu_pkg::SIU_CMD_REG_WR);
		dev(8'hD0, 8'h00, siu_pkg::SIU_CMD_REG_RD);
		rrd(siu_pkg::SIU_REGRD_OFS, 32'h9, "clear_one");
		dev(8'hD1, 8'hF7, siu_pkg::SIU_CMD_REG_WR);
		chk("clear_watch", 32'(pending), 32'h9);
		ahb(1'b1, siu_pkg::SIU_PC_OFS, 32'h0);
		cmd(siu_pkg::SIU_CMD_INT_RET);
		wait_idle();
		rrd(siu_pkg::SIU_PC_OFS, 32'h1234, "pc_back");
		rrd(siu_pkg::SIU_FLAGS_OFS, 32'hA5, "flags_back");
		chk("gen_back", 32'(gen), 32'h1);
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h4, "restore_seen");
		cmd(siu_pkg::SIU_CMD_BOUNDARY);
		wait_idle();
		rrd(siu_pkg::SIU_IRQ_STAT_OFS, 32'h7, "second_ack");
		dev(8'hD0, 8'h00, siu_pkg::SIU_CMD_REG_WR);
		dev(8'hD1, 8'h00, siu_pkg::SIU_CMD_REG_WR);
		for (i = 0; i < 14; i++) begin
			m = 8'h1 << (i % 8);
			pulse(14'h0001 << i);
			chk("source", 32'(pending), 32'h1 << i);
			dev((i < 8) ? 8'hD0 : 8'hD1, ~m, siu_pkg::SIU_CMD_REG_WR);
		end
		chk("all_clear", 32'(pending), 32'h0);
		summarize();
	end
endmodule : siu_tb_top
